// ===== hw/osr_core.v
// Origin search and origin return motion profile with positioning monitor.
// Assumes a synchronous register port, synchronous sensor inputs and a pulse generator fed by speed_q.
`timescale 1ns/1ps
`include "osr_map.vh"
// Notes on behaviour
// R01: Proximity speed after proximity input, max 100k
// R02: Refuse search unless high>prox>initial
// R03: Emit correction pulses, zero position, clear flag
// R04: Search acceleration adds rate every 4 ms
// R05: Search deceleration subtracts rate every 4 ms
// R06: Mode 2 waits monitor time for completion
// R07: Missing completion raises timeout code 0300
// R08: Monitor rounded up to 10 ms, +10
// R09: Zero monitor time waits forever, no error
// R10: Return drives toward target speed 1..100k
// R11: Return accelerates by rate per 4 ms
// R12: Return decelerates by rate per 4 ms
// R13: Search settings take effect after restart
// R14: Apply strobe loads new settings while running
// R15: Completion input only used in mode 2
// R16: Present position is signed 32-bit
module osr_core (
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // Register port
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // Sensors and drive
   input wire prox_in,
   input wire origin_in,
   input wire pos_done_in,
   input wire pulse_sent,
   output reg [31:0] speed_q,
   output reg dir_q,
   output reg busy_q,
   output reg irq_q
);
   // ****************************************************************
   // States
   // ****************************************************************
   localparam ST_IDLE = 3'd0;
   localparam ST_SRCH = 3'd1;
   localparam ST_PROX = 3'd2;
   localparam ST_CORR = 3'd3;
   localparam ST_RET = 3'd4;
   localparam ST_WAIT = 3'd5;
   localparam [31:0] TICK_CYC = `OSR_TICK_CYC;
   localparam [31:0] MS_CYC = `OSR_MS_CYC;

   // ****************************************************************
   // Settings: staged copies and live copies
   // ****************************************************************
   reg [1:0] mode_q, mode_s;
   reg [31:0] init_q, init_s, high_q, high_s, prox_q, prox_s, corr_q, corr_s;
   reg [15:0] sacc_q, sacc_s, sdec_q, sdec_s, mon_q, mon_s;
   reg [31:0] rspd_q, rspd_s;
   reg [15:0] racc_q, racc_s, rdec_q, rdec_s;
   reg [2:0] st_q;
   reg signed [31:0] pos_q;
   reg signed [31:0] corr_left_q;
   reg no_origin_q;
   reg [31:0] tick_q, ms_q;
   reg [15:0] mon_ms_q, mon_lim_q;
   reg mon_inf_q;
   reg [15:0] err_q;
   reg [`OSR_EV_W-1:0] ev_q, en_q;
   reg [31:0] goal_q;
   reg [15:0] acc_q, dec_q;
   reg after_ret_q;
   wire tick = (tick_q == TICK_CYC - 32'd1);

   // Clamp to the legal speed range
   function [31:0] clamp_spd;
      input [31:0] v;
      begin
         clamp_spd = (v > `OSR_SPD_MAX) ? `OSR_SPD_MAX : v;
      end
   endfunction

   // One 4 ms ramp step toward the goal, never overshooting
   function [31:0] ramp;
      input [31:0] cur;
      input [31:0] goal;
      input [15:0] up;
      input [15:0] dn;
      begin
         if (cur < goal)
            ramp = (goal - cur > {16'h0000, up}) ? cur + {16'h0000, up} : goal;
         else if (cur > goal)
            ramp = (cur - goal > {16'h0000, dn}) ? cur - {16'h0000, dn} : goal;
         else
            ramp = cur;
      end
   endfunction

   // Effective monitor limit in ms: rounded up to a 10 ms step, plus one step
   function [15:0] mon_limit;
      input [15:0] t;
      reg [15:0] r;
      begin
         r = (t + 16'd9) / 16'd10;
         mon_limit = (r + 16'd1) * 16'd10;
      end
   endfunction

   wire wr_ctrl = reg_wr && reg_addr == `OSR_REG_CTRL;
   wire go_srch = wr_ctrl && reg_wdata[`OSR_CTRL_SEARCH];
   wire go_ret = wr_ctrl && reg_wdata[`OSR_CTRL_RETURN];
   wire abort = wr_ctrl && reg_wdata[`OSR_CTRL_ABORT];
   wire srch_ok = (high_q > prox_q) && (prox_q > init_q);
   reg [`OSR_EV_W-1:0] ev_set;

   // ****************************************************************
   // Register writes
   // ****************************************************************
   always @(posedge clock) begin
      if (sys_rst) begin
         // Staged values become live at reset (power restart); mode and monitor time only here [R13]
         mode_q <= mode_s;
         init_q <= init_s;
         high_q <= high_s;
         prox_q <= prox_s;
         corr_q <= corr_s;
         sacc_q <= sacc_s;
         sdec_q <= sdec_s;
         mon_q <= mon_s;
         rspd_q <= rspd_s;
         racc_q <= racc_s;
         rdec_q <= rdec_s;
         en_q <= {`OSR_EV_W{1'b0}};
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `OSR_REG_MODE: mode_s <= reg_wdata[1:0];
               `OSR_REG_INIT_SPD: init_s <= clamp_spd(reg_wdata);
               `OSR_REG_HIGH_SPD: high_s <= clamp_spd(reg_wdata);
               `OSR_REG_PROX_SPD: prox_s <= clamp_spd(reg_wdata); // [R01]
               `OSR_REG_CORR: corr_s <= reg_wdata;
               `OSR_REG_SRCH_ACC: sacc_s <= reg_wdata[15:0];
               `OSR_REG_SRCH_DEC: sdec_s <= reg_wdata[15:0];
               `OSR_REG_MON_TIME: mon_s <= (reg_wdata[15:0] > `OSR_MON_MAX) ? `OSR_MON_MAX : reg_wdata[15:0];
               `OSR_REG_RET_SPD: rspd_s <= (reg_wdata == 32'h0000_0000) ? 32'h0000_0001 : clamp_spd(reg_wdata); // [R10]
               `OSR_REG_RET_ACC: racc_s <= reg_wdata[15:0];
               `OSR_REG_RET_DEC: rdec_s <= reg_wdata[15:0];
               `OSR_REG_IRQ_EN: en_q <= reg_wdata[`OSR_EV_W-1:0];
               default: ;
            endcase
         end
         // Runtime parameter change instruction: copy staged set live now, except mode and monitor time [R14]
         if (reg_wr && reg_addr == `OSR_REG_APPLY) begin
            init_q <= init_s;
            high_q <= high_s;
            prox_q <= prox_s;
            corr_q <= corr_s;
            sacc_q <= sacc_s;
            sdec_q <= sdec_s;
            rspd_q <= rspd_s;
            racc_q <= racc_s;
            rdec_q <= rdec_s;
         end
      end
   end

   // Staged copies need a known value; reset only loads the live side
   initial begin
      mode_s = 2'h0; init_s = 32'h0000_0000; high_s = 32'h0000_0000; prox_s = 32'h0000_0000;
      corr_s = 32'h0000_0000; sacc_s = 16'h0000; sdec_s = 16'h0000; mon_s = 16'h0000;
      rspd_s = 32'h0000_0001; racc_s = 16'h0000; rdec_s = 16'h0000;
   end

   // ****************************************************************
   // Motion sequencer
   // ****************************************************************
   always @(posedge clock) begin
      if (sys_rst) begin
         st_q <= ST_IDLE;
         speed_q <= 32'h0000_0000;
         dir_q <= 1'b0;
         busy_q <= 1'b0;
         pos_q <= 32'sh0000_0000;
         corr_left_q <= 32'sh0000_0000;
         no_origin_q <= 1'b1;
         tick_q <= 32'h0000_0000;
         ms_q <= 32'h0000_0000;
         mon_ms_q <= 16'h0000;
         mon_lim_q <= 16'h0000;
         mon_inf_q <= 1'b0;
         err_q <= 16'h0000;
         goal_q <= 32'h0000_0000;
         acc_q <= 16'h0000;
         dec_q <= 16'h0000;
         after_ret_q <= 1'b0;
         ev_set <= {`OSR_EV_W{1'b0}};
      end else begin
         ev_set <= {`OSR_EV_W{1'b0}};
         tick_q <= (st_q == ST_IDLE || tick) ? 32'h0000_0000 : tick_q + 32'd1;
         // Position follows emitted pulses [R16]
         if (pulse_sent && st_q != ST_IDLE && st_q != ST_WAIT)
            pos_q <= dir_q ? pos_q - 32'sd1 : pos_q + 32'sd1;
         if (tick && st_q != ST_IDLE && st_q != ST_WAIT)
            speed_q <= ramp(speed_q, goal_q, acc_q, dec_q); // [R04] [R05] [R11] [R12]
         // Clear first so a timeout in the same cycle still lands
         if (wr_ctrl && err_q != 16'h0000)
            err_q <= 16'h0000;
         case (st_q)
            ST_IDLE: begin
               busy_q <= 1'b0;
               if (go_srch) begin
                  if (!srch_ok) begin
                     ev_set[`OSR_EV_REFUSED] <= 1'b1; // [R02]
                  end else begin
                     st_q <= ST_SRCH;
                     busy_q <= 1'b1;
                     speed_q <= init_q;
                     goal_q <= high_q;
                     acc_q <= sacc_q;
                     dec_q <= sdec_q;
                     dir_q <= 1'b0;
                  end
               end else if (go_ret) begin
                  st_q <= ST_RET;
                  busy_q <= 1'b1;
                  speed_q <= init_q;
                  goal_q <= rspd_q; // [R10]
                  acc_q <= racc_q; // [R11]
                  dec_q <= rdec_q; // [R12]
                  dir_q <= pos_q > 32'sh0000_0000;
               end
            end
            ST_SRCH: if (prox_in) begin
               goal_q <= prox_q; // [R01]
               st_q <= ST_PROX;
            end
            ST_PROX: if (origin_in) begin
               corr_left_q <= corr_q; // [R03]
               dir_q <= corr_q[31];
               pos_q <= 32'sh0000_0000;
               speed_q <= init_q;
               goal_q <= init_q;
               st_q <= ST_CORR;
            end
            ST_CORR: begin
               if (corr_left_q == 32'sh0000_0000) begin
                  speed_q <= 32'h0000_0000;
                  after_ret_q <= 1'b0;
                  st_q <= ST_WAIT;
               end else if (pulse_sent) begin
                  corr_left_q <= corr_left_q[31] ? corr_left_q + 32'sd1 : corr_left_q - 32'sd1;
               end
            end
            ST_RET: begin
               if (pos_q == 32'sh0000_0000 || (pulse_sent && (dir_q ? pos_q == 32'sd1 : pos_q == -32'sd1))) begin
                  speed_q <= 32'h0000_0000;
                  after_ret_q <= 1'b1;
                  st_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (mode_q != `OSR_MODE_SERVO_INP || pos_done_in) begin // [R15] [R06]
                  if (!after_ret_q)
                     pos_q <= 32'sh0000_0000; // [R03]
                  no_origin_q <= 1'b0; // [R03]
                  ev_set[`OSR_EV_DONE] <= 1'b1;
                  st_q <= ST_IDLE;
               end else if (!mon_inf_q && mon_ms_q >= mon_lim_q) begin
                  err_q <= `OSR_ERR_TIMEOUT; // [R07]
                  ev_set[`OSR_EV_TIMEOUT] <= 1'b1;
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
         // Monitor timer starts fresh on every entry to the wait
         if (st_q != ST_WAIT) begin
            ms_q <= 32'h0000_0000;
            mon_ms_q <= 16'h0000;
            mon_lim_q <= mon_limit(mon_q); // [R08]
            mon_inf_q <= (mon_q == 16'h0000); // [R09]
         end else if (ms_q == MS_CYC - 32'd1) begin
            ms_q <= 32'h0000_0000;
            mon_ms_q <= mon_ms_q + 16'd1; // [R06]
         end else begin
            ms_q <= ms_q + 32'd1;
         end
         if (abort) begin
            st_q <= ST_IDLE;
            speed_q <= 32'h0000_0000;
         end
      end
   end

   // ****************************************************************
   // Interrupts and read port
   // ****************************************************************
   always @(posedge clock) begin
      if (sys_rst) begin
         ev_q <= {`OSR_EV_W{1'b0}};
         irq_q <= 1'b0;
         reg_rdata <= 32'h0000_0000;
      end else begin
         // Set wins over a clear in the same cycle
         ev_q <= (ev_q & ~((reg_wr && reg_addr == `OSR_REG_IRQ_CLR) ? reg_wdata[`OSR_EV_W-1:0]
                 : {`OSR_EV_W{1'b0}})) | ev_set;
         irq_q <= |(ev_q & en_q);
         reg_rdata <= 32'h0000_0000;
         if (reg_rd) begin
            case (reg_addr)
               `OSR_REG_MODE: reg_rdata <= {30'h0000_0000, mode_s};
               `OSR_REG_INIT_SPD: reg_rdata <= init_s;
               `OSR_REG_HIGH_SPD: reg_rdata <= high_s;
               `OSR_REG_PROX_SPD: reg_rdata <= prox_s;
               `OSR_REG_CORR: reg_rdata <= corr_s;
               `OSR_REG_SRCH_ACC: reg_rdata <= {16'h0000, sacc_s};
               `OSR_REG_SRCH_DEC: reg_rdata <= {16'h0000, sdec_s};
               `OSR_REG_MON_TIME: reg_rdata <= {16'h0000, mon_s};
               `OSR_REG_RET_SPD: reg_rdata <= rspd_s;
               `OSR_REG_RET_ACC: reg_rdata <= {16'h0000, racc_s};
               `OSR_REG_RET_DEC: reg_rdata <= {16'h0000, rdec_s};
               `OSR_REG_STATUS: reg_rdata <= {25'h0000_000, no_origin_q, busy_q, 2'h0, st_q};
               `OSR_REG_POS: reg_rdata <= pos_q;
               `OSR_REG_SPEED: reg_rdata <= speed_q;
               `OSR_REG_ERR_CODE: reg_rdata <= {16'h0000, err_q};
               `OSR_REG_IRQ_STAT: reg_rdata <= {29'h0000_0000, ev_q};
               `OSR_REG_IRQ_EN: reg_rdata <= {29'h0000_0000, en_q};
               default: reg_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// ===== pkg/osr_map.vh
// Register map, field codes and timing counts of the origin search/return block.
// Assumes a 125 MHz system clock and a word-wide register port.
`ifndef OSR_MAP_VH
`define OSR_MAP_VH
// ****************************************************************
// Register offsets (word index, byte address is four times)
// ****************************************************************
`define OSR_REG_CTRL 8'h00
`define OSR_REG_MODE 8'h01
`define OSR_REG_INIT_SPD 8'h02
`define OSR_REG_HIGH_SPD 8'h03
`define OSR_REG_PROX_SPD 8'h04
`define OSR_REG_CORR 8'h05
`define OSR_REG_SRCH_ACC 8'h06
`define OSR_REG_SRCH_DEC 8'h07
`define OSR_REG_MON_TIME 8'h08
`define OSR_REG_RET_SPD 8'h09
`define OSR_REG_RET_ACC 8'h0a
`define OSR_REG_RET_DEC 8'h0b
`define OSR_REG_APPLY 8'h0c
`define OSR_REG_STATUS 8'h0d
`define OSR_REG_POS 8'h0e
`define OSR_REG_SPEED 8'h0f
`define OSR_REG_ERR_CODE 8'h10
`define OSR_REG_IRQ_STAT 8'h11
`define OSR_REG_IRQ_EN 8'h12
`define OSR_REG_IRQ_CLR 8'h13
// ****************************************************************
// Control bits (CTRL, write-one pulses)
// ****************************************************************
`define OSR_CTRL_SEARCH 0
`define OSR_CTRL_RETURN 1
`define OSR_CTRL_ABORT 2
// ****************************************************************
// Interrupt / status bits
// ****************************************************************
`define OSR_EV_DONE 0
`define OSR_EV_REFUSED 1
`define OSR_EV_TIMEOUT 2
`define OSR_EV_W 3
// ****************************************************************
// Limits, codes and timing
// ****************************************************************
`define OSR_SPD_MAX 32'h0001_86a0
`define OSR_MON_MAX 16'h270f
`define OSR_ERR_TIMEOUT 16'h0300
`define OSR_MODE_SERVO_INP 2'h2
`define OSR_CLK_HZ 125000000
`define OSR_TICK_MS 4
`define OSR_TICK_CYC (`OSR_CLK_HZ / 1000 * `OSR_TICK_MS)
`define OSR_MS_CYC (`OSR_CLK_HZ / 1000)
`define OSR_MON_STEP_MS 10
`endif

// ===== verif/osr_core_assertions.sv
// Port-level checks of the origin search/return core.
// Assumes one clock domain and the register map header.
`timescale 1ns/1ps
`include "osr_map.vh"
module osr_core_assertions (
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // Register port
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   // Sensors and drive
   input wire prox_in,
   input wire origin_in,
   input wire pos_done_in,
   input wire pulse_sent,
   input wire [31:0] speed_q,
   input wire dir_q,
   input wire busy_q,
   input wire irq_q
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // ****
   // Command sequences
   // ****
   sequence ret_cmd_s;
      reg_wr && reg_addr == `OSR_REG_CTRL && reg_wdata[2:0] == 3'h2 && !busy_q;
   endsequence
   sequence abort_cmd_s;
      reg_wr && reg_addr == `OSR_REG_CTRL && reg_wdata[2] && busy_q;
   endsequence
   sequence mask_s;
      (reg_wr && reg_addr == `OSR_REG_IRQ_EN && reg_wdata == 32'h0000_0000) ##1 !(reg_wr && reg_addr == `OSR_REG_IRQ_EN);
   endsequence
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data not zero outside read slot");
   unmapped_rd_a: assert property (reg_rd && reg_addr > 8'h13 |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   wo_read_a: assert property (reg_rd && (reg_addr == `OSR_REG_CTRL || reg_addr == `OSR_REG_APPLY
      || reg_addr == `OSR_REG_IRQ_CLR) |=> reg_rdata == 32'h0000_0000)
      else $error("write-only register read not zero");
   ret_start_a: assert property (ret_cmd_s |-> ##[1:2] busy_q)
      else $error("return did not start");
   abort_stop_a: assert property (abort_cmd_s |-> ##[1:8] !busy_q)
      else $error("abort did not stop motion");
   irq_mask_a: assert property (mask_s |=> !irq_q)
      else $error("interrupt high while masked");
   spd_cap_a: assert property (speed_q <= `OSR_SPD_MAX)
      else $error("speed above maximum");
   acc_step_a: assert property (busy_q && $past(busy_q) && speed_q > $past(speed_q)
      |-> speed_q - $past(speed_q) <= 32'h0000_ffff)
      else $error("speed step above rate limit");
endmodule
bind osr_core osr_core_assertions i_osr_core_assertions (
   .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prox_in(prox_in), .origin_in(origin_in),
   .pos_done_in(pos_done_in), .pulse_sent(pulse_sent), .speed_q(speed_q), .dir_q(dir_q),
   .busy_q(busy_q), .irq_q(irq_q)
);

// ===== verif/osr_core_tb.sv
// Self-checking bench of the origin search/return core.
// Assumes staged settings survive reset; timeouts are too long to reach.
`timescale 1ns/1ps
`include "osr_map.vh"
module osr_core_tb;
   reg clock = 1'b0;
   reg sys_rst = 1'b1;
   reg [7:0] reg_addr = 8'h00;
   reg [31:0] reg_wdata = 32'h0000_0000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg prox_in = 1'b0;
   reg origin_in = 1'b0;
   reg pulse_on = 1'b0;
   reg inp_go = 1'b0;
   wire [31:0] reg_rdata;
   wire [31:0] speed_q;
   wire pos_done_in, pulse_sent, dir_q, busy_q, irq_q;
   integer err_total = 0;
   integer samples_checked = 0;
   integer pulse_cnt = 0;
   integer cyc = 0;
   reg [31:0] rv;
   osr_core i_osr_core (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prox_in(prox_in), .origin_in(origin_in),
      .pos_done_in(pos_done_in), .pulse_sent(pulse_sent), .speed_q(speed_q), .dir_q(dir_q),
      .busy_q(busy_q), .irq_q(irq_q));
   // Pulse generator idles at zero speed, so no stray pulse after the correction
   osr_drive_model i_osr_drive_model (.clock(clock), .sys_rst(sys_rst),
      .busy(busy_q && speed_q != 32'h0000_0000), .pulse_on(pulse_on),
      .inp_go(inp_go), .pulse_sent(pulse_sent), .pos_done_in(pos_done_in));
   initial begin
      forever #4 clock = ~clock;
   end
   // ****
   // Bus, wait and compare helpers
   // ****
   always @(posedge clock) begin
      if (pulse_sent === 1'b1) pulse_cnt <= pulse_cnt + 1;
      cyc <= cyc + 1;
      // Hang guard, far above the expected run
      if (cyc == 20000) begin
         err_total = err_total + 1;
         results;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge clock);
         reg_wr <= 1'b0;
         @(posedge clock);
      end
   endtask
   task rd(input [7:0] a);
      begin
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clock);
         reg_rd <= 1'b0;
         @(posedge clock);
         rv = reg_rdata;
      end
   endtask
   task do_reset;
      begin
         sys_rst <= 1'b1;
         repeat (16) @(posedge clock);
         sys_rst <= 1'b0;
         @(posedge clock);
      end
   endtask
   task wait_idle(input integer lim);
      integer n;
      begin
         n = 0;
         while (busy_q !== 1'b0 && n < lim) begin
            @(posedge clock);
            n = n + 1;
         end
         chk({31'h0, busy_q}, 32'h0000_0000);
      end
   endtask
   task setup(input [31:0] i, input [31:0] h, input [31:0] p);
      begin
         wr(`OSR_REG_INIT_SPD, i);
         wr(`OSR_REG_HIGH_SPD, h);
         wr(`OSR_REG_PROX_SPD, p);
         wr(`OSR_REG_APPLY, 32'h0000_0001);
      end
   endtask
   // Start a search, pass proximity and origin, release correction pulses
   task run_search;
      begin
         wr(`OSR_REG_IRQ_CLR, 32'h0000_0007);
         wr(`OSR_REG_CTRL, 32'h0000_0001);
         chk({31'h0, busy_q}, 32'h0000_0001);
         chk(speed_q, 32'h0000_0064);
         prox_in <= 1'b1;
         repeat (4) @(posedge clock);
         origin_in <= 1'b1;
         pulse_cnt = 0;
         pulse_on <= 1'b1;
      end
   endtask
   // ****
   // Scenarios
   // ****
   task t_regs;
      begin
         rd(8'h3f);
         chk(rv, 32'h0000_0000);
         rd(`OSR_REG_CTRL);
         chk(rv, 32'h0000_0000);
         rd(`OSR_REG_STATUS);
         chk({30'h0, rv[6:5]}, 32'h0000_0002);
         wr(`OSR_REG_CORR, 32'h0000_0005);
         rd(`OSR_REG_CORR);
         chk(rv, 32'h0000_0005);
      end
   endtask
   task t_refuse;
      begin
         // Equal speeds are the boundary of both refusal cases
         setup(32'h0000_0064, 32'h0000_00c8, 32'h0000_00c8);
         wr(`OSR_REG_CTRL, 32'h0000_0001);
         chk({31'h0, busy_q}, 32'h0000_0000);
         setup(32'h0000_00c8, 32'h0000_01f4, 32'h0000_00c8);
         wr(`OSR_REG_IRQ_CLR, 32'h0000_0007);
         wr(`OSR_REG_CTRL, 32'h0000_0001);
         chk({31'h0, busy_q}, 32'h0000_0000);
         rd(`OSR_REG_IRQ_STAT);
         chk(rv, 32'h0000_0002);
         wr(`OSR_REG_IRQ_EN, 32'h0000_0002);
         @(posedge clock);
         chk({31'h0, irq_q}, 32'h0000_0001);
         wr(`OSR_REG_IRQ_EN, 32'h0000_0000);
         @(posedge clock);
         chk({31'h0, irq_q}, 32'h0000_0000);
         wr(`OSR_REG_IRQ_EN, 32'h0000_0002);
         wr(`OSR_REG_IRQ_CLR, 32'h0000_0007);
         @(posedge clock);
         chk({31'h0, irq_q}, 32'h0000_0000);
      end
   endtask
   task t_search_mode0;
      begin
         // Staged only: mode 2 must not act before a restart
         wr(`OSR_REG_MODE, {30'h0, `OSR_MODE_SERVO_INP});
         wr(`OSR_REG_MON_TIME, 32'h0000_0000);
         setup(32'h0000_0064, 32'h0000_01f4, 32'h0000_00c8);
         run_search;
         wait_idle(500);
         chk(pulse_cnt, 32'h0000_0005);
         {prox_in, origin_in, pulse_on} <= 3'h0;
         rd(`OSR_REG_POS);
         chk(rv, 32'h0000_0000);
         rd(`OSR_REG_STATUS);
         chk({31'h0, rv[6]}, 32'h0000_0000);
         rd(`OSR_REG_IRQ_STAT);
         chk(rv, 32'h0000_0001);
      end
   endtask
   task t_search_mode2;
      begin
         // Negative correction: reverse pulses, signed position
         wr(`OSR_REG_CORR, 32'hffff_fffd);
         do_reset;
         run_search;
         repeat (3000) @(posedge clock);
         chk({31'h0, busy_q}, 32'h0000_0001);
         chk({31'h0, dir_q}, 32'h0000_0001);
         chk(pulse_cnt, 32'h0000_0003);
         rd(`OSR_REG_POS);
         chk(rv, 32'hffff_fffd);
         rd(`OSR_REG_IRQ_STAT);
         chk({31'h0, rv[2]}, 32'h0000_0000);
         rd(`OSR_REG_ERR_CODE);
         chk(rv, 32'h0000_0000);
         inp_go <= 1'b1;
         wait_idle(100);
         {prox_in, origin_in, pulse_on, inp_go} <= 4'h0;
         rd(`OSR_REG_POS);
         chk(rv, 32'h0000_0000);
         rd(`OSR_REG_IRQ_STAT);
         chk(rv, 32'h0000_0001);
      end
   endtask
   task t_return;
      begin
         wr(`OSR_REG_RET_SPD, 32'h0000_01f4);
         wr(`OSR_REG_APPLY, 32'h0000_0001);
         wr(`OSR_REG_CTRL, 32'h0000_0002);
         chk({31'h0, busy_q}, 32'h0000_0001);
         wr(`OSR_REG_CTRL, 32'h0000_0004);
         wait_idle(20);
      end
   endtask
   task results;
      begin
         $display("checked %0d errors %0d", samples_checked, err_total);
         if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   initial begin
      do_reset;
      t_regs;
      t_refuse;
      t_search_mode0;
      t_search_mode2;
      t_return;
      results;
   end
endmodule

// ===== verif/osr_drive_model.sv
// Drive-side model: pulse generator echo and positioning-completed input.
// Assumes the bench gates pulses and in-position through pulse_on and inp_go.
`timescale 1ns/1ps
module osr_drive_model #(
   parameter SETTLE = 8
) (
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // Block and bench controls
   input wire busy,
   input wire pulse_on,
   input wire inp_go,
   // Drive outputs
   output reg pulse_sent,
   output reg pos_done_in
);
   reg [1:0] div_q;
   reg [7:0] settle_q;
   // ****
   // One pulse every 4 cycles, in-position after a settle delay
   // ****
   always @(posedge clock) begin
      if (sys_rst) begin
         div_q <= 2'h0;
         settle_q <= 8'h00;
         pulse_sent <= 1'b0;
         pos_done_in <= 1'b0;
      end else begin
         div_q <= div_q + 2'h1;
         pulse_sent <= busy && pulse_on && (div_q == 2'h3);
         // Slow drive: completion only after the settle count
         settle_q <= inp_go ? ((settle_q == SETTLE) ? settle_q : settle_q + 8'h01) : 8'h00;
         pos_done_in <= inp_go && (settle_q == SETTLE);
      end
   end
endmodule
